// *** verilog/ccs_pkg.sv ***
// constants and types shared by the charger configuration slave
package ccs_pkg;
   // ----------------------------------------------------------------
   // bus addressing
   // ----------------------------------------------------------------
   localparam logic [6:0] CCS_SLAVE_ADDR      = 7'h6B;
   localparam logic [7:0] CCS_OFS_SOURCE_CTRL = 8'h00;
   localparam logic [7:0] CCS_OFS_POWER_CFG   = 8'h01;
   localparam logic [7:0] CCS_OFS_SPARE_FIRST = 8'h02;
   localparam logic [7:0] CCS_OFS_RW_LAST     = 8'h07;
   localparam logic [7:0] CCS_OFS_STATUS      = 8'h08;
   localparam logic [7:0] CCS_OFS_FAULT       = 8'h09;
   localparam logic [7:0] CCS_OFS_LAST        = 8'h0A;
   localparam logic [3:0] CCS_BYTE_BITS       = 4'h8;
   localparam logic [3:0] CCS_LAST_BIT        = 4'h7;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int         CCS_CFG_REG_RESET_BIT = 7;
   localparam int         CCS_CFG_KICK_BIT      = 6;
   localparam logic       CCS_HIZ_RST           = 1'b0;
   localparam logic [3:0] CCS_FLOOR_RST         = 4'h6;
   localparam logic [2:0] CCS_CAP_SEL_LOW       = 3'h7;
   localparam logic [2:0] CCS_CAP_SEL_HIGH_LOW  = 3'h0;
   localparam logic [2:0] CCS_CAP_SEL_HIGH_HIGH = 3'h2;
   localparam logic [5:0] CCS_CFG_RST           = 6'h1B;
   localparam logic [7:0] CCS_SPARE_RST         = 8'h00;
   localparam logic [7:0] CCS_UNMAPPED_READ     = 8'h00;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int         CCS_CLK_MHZ      = 20;
   localparam int         CCS_KICK_GAP_NS  = 20000;
   localparam logic [8:0] CCS_KICK_GAP_CYC =
      9'((CCS_KICK_GAP_NS * CCS_CLK_MHZ + 999) / 1000);
   localparam logic [2:0] CCS_STRETCH_CYC  = 3'h2;
   localparam logic [1:0] CCS_STRAP_CYC    = 2'h3;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CCS_ST_IDLE = 3'b000,
      CCS_ST_RX   = 3'b001,
      CCS_ST_ACK  = 3'b010,
      CCS_ST_TX   = 3'b011,
      CCS_ST_MACK = 3'b100
   } ccs_state_t;

   typedef enum logic [1:0] {
      CCS_STG_ADDR = 2'b00,
      CCS_STG_REG  = 2'b01,
      CCS_STG_DATA = 2'b10
   } ccs_stage_t;

   typedef struct packed {
      logic       input_high_impedance_enable;
      logic [3:0] input_voltage_floor;
      logic [2:0] input_current_cap;
   } ccs_source_ctrl_t;

   typedef struct packed {
      logic       boost_output_enable;
      logic       charge_enable;
      logic [2:0] minimum_system_voltage;
      logic       boost_current_cap;
   } ccs_power_cfg_t;
endpackage

// *** verilog/ccs_sync.sv ***
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none
module ccs_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_reset,
   input  wire logic [W-1:0] i_async,
   input  wire logic [W-1:0] i_rst_val,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_sync;

   always_comb begin
      next_meta = i_async;
      next_sync = meta;
   end

   // reset value only matters for a bus idling high; parent passes a constant
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         meta   <= '1;
         o_sync <= '1;
      end else begin
         meta   <= next_meta;
         o_sync <= next_sync;
      end
   end

   logic unused_rst;
   assign unused_rst = ^i_rst_val;
endmodule // ccs_sync
`default_nettype wire

// *** verilog/ccs_fault_latch.sv ***
// read-to-clear fault latch
`timescale 1ns/1ns
`default_nettype none
module ccs_fault_latch #(
   parameter int W = 7
) (
   input  wire logic         i_clk,
   input  wire logic         i_reset,
   input  wire logic [W-1:0] i_fault,
   input  wire logic         i_read_clear,
   output logic      [W-1:0] o_latched
);
   logic [W-1:0] next_latched;

   // a fault present in the clearing cycle survives the clear
   always_comb begin
      next_latched = o_latched | i_fault;
      if (i_read_clear) begin
         next_latched = i_fault;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_latched <= '0;
      end else begin
         o_latched <= next_latched;
      end
   end

   fault_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
      i_read_clear |=> (o_latched == $past(i_fault)))
      else $error("fault latch did not fall to present condition on read");
   fault_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (!i_read_clear && (o_latched != '0)) |=> ((o_latched & $past(o_latched)) == $past(o_latched)))
      else $error("latched fault lost without a read");
endmodule // ccs_fault_latch
`default_nettype wire

// *** verilog/ccs_config_slave.sv ***
// serial slave port with input source and power-on configuration registers
`timescale 1ns/1ns
`default_nettype none
module ccs_config_slave #(
   parameter logic [7:0] REVISION_ID = 8'h00   // arbitrary value
) (
   input  wire logic                      i_clk,
   input  wire logic                      i_reset,
   input  wire logic                      i_scl,
   output logic                           o_scl_o,
   output logic                           o_scl_oe,
   input  wire logic                      i_sda,
   output logic                           o_sda_o,
   output logic                           o_sda_oe,
   input  wire logic                      i_source_select,
   input  wire logic                      i_boost_request,
   input  wire logic [7:0]                i_status,
   input  wire logic [6:0]                i_fault,
   input  wire logic                      i_watchdog_expired,
   output ccs_pkg::ccs_source_ctrl_t      o_source_ctrl,
   output ccs_pkg::ccs_power_cfg_t        o_power_cfg,
   output logic                           o_charge_active,
   output logic                           o_watchdog_kick,
   output logic                           o_default_mode
);
   import ccs_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers and edge detection
   // ----------------------------------------------------------------
   logic [3:0] pins_s;
   logic       scl_s, sda_s, psel_s, boost_s;
   logic       scl_d, sda_d;

   ccs_sync #(.W(4)) u_sync (
      .i_clk     (i_clk),
      .i_reset   (i_reset),
      .i_async   ({i_scl, i_sda, i_source_select, i_boost_request}),
      .i_rst_val (4'hF),
      .o_sync    (pins_s)
   );
   assign {scl_s, sda_s, psel_s, boost_s} = pins_s;

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   logic scl_rise, scl_fall, start_cond, stop_cond;
   assign scl_rise   = scl_s & ~scl_d;
   assign scl_fall   = ~scl_s & scl_d;
   assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

   // ----------------------------------------------------------------
   // register read mux and fault latch
   // ----------------------------------------------------------------
   ccs_source_ctrl_t  src;
   ccs_power_cfg_t    cfg;
   logic [5:0][7:0]   spare;
   logic [6:0]        fault_latched;
   logic              fault_rd;
   logic [7:0]        ptr;
   logic [7:0]        rd_byte;

   ccs_fault_latch #(.W(7)) u_fault (
      .i_clk        (i_clk),
      .i_reset      (i_reset),
      .i_fault      (i_fault),
      .i_read_clear (fault_rd),
      .o_latched    (fault_latched)
   );

   always_comb begin
      rd_byte = CCS_UNMAPPED_READ;
      if (ptr == CCS_OFS_SOURCE_CTRL) begin
         rd_byte = src;
      end else if (ptr == CCS_OFS_POWER_CFG) begin
         rd_byte = {2'b00, cfg};   // reset and kick bits read as zero
      end else if (ptr <= CCS_OFS_RW_LAST) begin
         rd_byte = spare[3'(ptr[2:0] - 3'h2)];
      end else if (ptr == CCS_OFS_STATUS) begin
         rd_byte = i_status;
      end else if (ptr == CCS_OFS_FAULT) begin
         rd_byte = {o_default_mode, fault_latched};
      end else if (ptr == CCS_OFS_LAST) begin
         rd_byte = REVISION_ID;
      end
   end

   // ----------------------------------------------------------------
   // link state machine
   // ----------------------------------------------------------------
   ccs_state_t state, next_state;
   ccs_stage_t stage, next_stage;
   logic [3:0] bitcnt, next_bitcnt;
   logic [7:0] shift, next_shift;
   logic [7:0] next_ptr;
   logic       rw, next_rw;
   logic       first, next_first;
   logic       sda_oe, next_sda_oe;
   logic [2:0] stretch, next_stretch;
   logic       wr_stb;
   logic       accept;
   logic [7:0] load_byte;

   always_comb begin
      next_state   = state;
      next_stage   = stage;
      next_bitcnt  = bitcnt;
      next_shift   = shift;
      next_ptr     = ptr;
      next_rw      = rw;
      next_first   = first;
      next_sda_oe  = sda_oe;
      next_stretch = (stretch != 3'h0) ? stretch - 3'h1 : 3'h0;
      wr_stb       = 1'b0;
      fault_rd     = 1'b0;
      accept       = 1'b0;
      // fault register is returned only as the first byte of a read
      load_byte    = (ptr == CCS_OFS_FAULT && !first) ? CCS_UNMAPPED_READ : rd_byte;
      if (start_cond) begin
         next_state   = CCS_ST_RX;
         next_stage   = CCS_STG_ADDR;
         next_bitcnt  = 4'h0;
         next_sda_oe  = 1'b0;
         next_stretch = 3'h0;
      end else if (stop_cond) begin
         next_state  = CCS_ST_IDLE;
         next_sda_oe = 1'b0;
      end else begin
         case (state)
            CCS_ST_RX: begin
               if (scl_rise && bitcnt < CCS_BYTE_BITS) begin
                  next_shift  = {shift[6:0], sda_s};
                  next_bitcnt = bitcnt + 4'h1;
               end else if (scl_fall && bitcnt == CCS_BYTE_BITS) begin
                  case (stage)
                     CCS_STG_ADDR: begin
                        accept     = (shift[7:1] == CCS_SLAVE_ADDR);
                        next_rw    = shift[0];
                        next_first = 1'b1;
                     end
                     CCS_STG_REG: begin
                        accept   = (shift <= CCS_OFS_LAST);
                        next_ptr = shift;
                     end
                     default: begin
                        accept = (ptr <= CCS_OFS_RW_LAST);
                        wr_stb = accept;
                        if (accept) begin
                           next_ptr = ptr + 8'h01;
                        end
                     end
                  endcase
                  next_state  = accept ? CCS_ST_ACK : CCS_ST_IDLE;
                  next_sda_oe = accept;
               end
            end
            CCS_ST_ACK: begin
               if (scl_fall) begin
                  next_bitcnt  = 4'h0;
                  next_stretch = CCS_STRETCH_CYC;
                  if (stage == CCS_STG_ADDR && rw) begin
                     next_state  = CCS_ST_TX;
                     next_stage  = CCS_STG_DATA;
                     next_shift  = load_byte;
                     next_sda_oe = ~load_byte[7];
                     fault_rd    = (ptr == CCS_OFS_FAULT);
                     next_first  = 1'b0;
                     next_ptr    = (ptr <= CCS_OFS_LAST) ? ptr + 8'h01 : ptr;
                  end else begin
                     next_state  = CCS_ST_RX;
                     next_sda_oe = 1'b0;
                     next_stage  = (stage == CCS_STG_ADDR) ? CCS_STG_REG : CCS_STG_DATA;
                  end
               end
            end
            CCS_ST_TX: begin
               if (scl_fall) begin
                  if (bitcnt == CCS_LAST_BIT) begin
                     next_state  = CCS_ST_MACK;
                     next_sda_oe = 1'b0;
                     next_bitcnt = 4'h0;
                  end else begin
                     next_shift  = {shift[6:0], 1'b0};
                     next_sda_oe = ~shift[6];
                     next_bitcnt = bitcnt + 4'h1;
                  end
               end
            end
            CCS_ST_MACK: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     next_state = CCS_ST_IDLE;
                  end else begin
                     next_bitcnt = CCS_BYTE_BITS;
                  end
               end else if (scl_fall && bitcnt == CCS_BYTE_BITS) begin
                  next_state   = CCS_ST_TX;
                  next_bitcnt  = 4'h0;
                  next_stretch = CCS_STRETCH_CYC;
                  next_shift   = load_byte;
                  next_sda_oe  = ~load_byte[7];
                  next_ptr     = (ptr <= CCS_OFS_LAST) ? ptr + 8'h01 : ptr;
               end
            end
            default: begin
               next_state  = CCS_ST_IDLE;
               next_sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state   <= CCS_ST_IDLE;
         stage   <= CCS_STG_ADDR;
         bitcnt  <= 4'h0;
         shift   <= 8'h00;
         ptr     <= 8'h00;
         rw      <= 1'b0;
         first   <= 1'b0;
         sda_oe  <= 1'b0;
         stretch <= 3'h0;
      end else begin
         state   <= next_state;
         stage   <= next_stage;
         bitcnt  <= next_bitcnt;
         shift   <= next_shift;
         ptr     <= next_ptr;
         rw      <= next_rw;
         first   <= next_first;
         sda_oe  <= next_sda_oe;
         stretch <= next_stretch;
      end
   end

   // open-drain: only ever pull low
   assign o_sda_o  = 1'b0;
   assign o_sda_oe = sda_oe;
   assign o_scl_o  = 1'b0;
   assign o_scl_oe = (stretch != 3'h0);

   // ----------------------------------------------------------------
   // register bank
   // ----------------------------------------------------------------
   ccs_source_ctrl_t next_src;
   ccs_power_cfg_t   next_cfg;
   logic [5:0][7:0]  next_spare;
   logic             next_default_mode, next_kick;
   logic [8:0]       kick_gap, next_kick_gap;
   logic [1:0]       strap_cnt, next_strap_cnt;
   logic [2:0]       strap_cap;

   assign strap_cap = !psel_s ? CCS_CAP_SEL_LOW :
                      (boost_s ? CCS_CAP_SEL_HIGH_HIGH : CCS_CAP_SEL_HIGH_LOW);

   always_comb begin
      next_src          = src;
      next_cfg          = cfg;
      next_spare        = spare;
      next_default_mode = o_default_mode;
      next_kick         = 1'b0;
      next_kick_gap     = (kick_gap != 9'h000) ? kick_gap - 9'h001 : 9'h000;
      next_strap_cnt    = strap_cnt;
      // pins are caught once the synchroniser has settled after reset
      if (strap_cnt != CCS_STRAP_CYC) begin
         next_strap_cnt = strap_cnt + 2'h1;
         if (strap_cnt == CCS_STRAP_CYC - 2'h1) begin
            next_src.input_current_cap = strap_cap;
         end
      end
      if (wr_stb) begin
         next_default_mode = 1'b0;
         if (ptr == CCS_OFS_SOURCE_CTRL) begin
            next_src = shift;
         end else if (ptr == CCS_OFS_POWER_CFG) begin
            if (shift[CCS_CFG_REG_RESET_BIT]) begin
               next_src.input_high_impedance_enable = CCS_HIZ_RST;
               next_src.input_voltage_floor         = CCS_FLOOR_RST;
               next_src.input_current_cap           = strap_cap;
               next_cfg                             = CCS_CFG_RST;
               next_spare                           = {6{CCS_SPARE_RST}};
            end else begin
               next_cfg = shift[5:0];
               if (shift[CCS_CFG_KICK_BIT] && kick_gap == 9'h000) begin
                  next_kick     = 1'b1;
                  next_kick_gap = CCS_KICK_GAP_CYC;
               end
            end
         end else begin
            next_spare[3'(ptr[2:0] - 3'h2)] = shift;
         end
      end
      if (i_watchdog_expired) begin
         next_default_mode = 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         src             <= {CCS_HIZ_RST, CCS_FLOOR_RST, CCS_CAP_SEL_LOW};
         cfg             <= CCS_CFG_RST;
         spare           <= {6{CCS_SPARE_RST}};
         o_default_mode  <= 1'b1;
         o_watchdog_kick <= 1'b0;
         kick_gap        <= 9'h000;
         strap_cnt       <= 2'h0;
      end else begin
         src             <= next_src;
         cfg             <= next_cfg;
         spare           <= next_spare;
         o_default_mode  <= next_default_mode;
         o_watchdog_kick <= next_kick;
         kick_gap        <= next_kick_gap;
         strap_cnt       <= next_strap_cnt;
      end
   end

   assign o_source_ctrl   = src;
   assign o_power_cfg     = cfg;
   assign o_charge_active = cfg.charge_enable & ~cfg.boost_output_enable;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   ack_drive_a: assert property ((state == CCS_ST_ACK) |-> o_sda_oe)
      else $error("ack bit not driven low");
   addr_mismatch_a: assert property (
      (state == CCS_ST_RX && stage == CCS_STG_ADDR && scl_fall && bitcnt == CCS_BYTE_BITS
       && !start_cond && !stop_cond && shift[7:1] != CCS_SLAVE_ADDR)
      |=> (state == CCS_ST_IDLE && !o_sda_oe))
      else $error("foreign address acknowledged");
   undef_reg_a: assert property (
      (state == CCS_ST_RX && stage == CCS_STG_REG && scl_fall && bitcnt == CCS_BYTE_BITS
       && !start_cond && !stop_cond && shift > CCS_OFS_LAST)
      |=> (state == CCS_ST_IDLE && !o_sda_oe))
      else $error("undefined register address acknowledged");
   read_only_a: assert property (wr_stb |-> (ptr <= CCS_OFS_RW_LAST))
      else $error("write reached a read-only register");
   boost_prio_a: assert property (o_power_cfg.boost_output_enable |-> !o_charge_active)
      else $error("charging while boost enabled");
   host_mode_a: assert property ((wr_stb && !i_watchdog_expired) |=> !o_default_mode)
      else $error("write did not leave default mode");
   reg_reset_a: assert property (
      (wr_stb && ptr == CCS_OFS_POWER_CFG && shift[CCS_CFG_REG_RESET_BIT] && !i_watchdog_expired)
      |=> (o_power_cfg == CCS_CFG_RST && o_source_ctrl.input_voltage_floor == CCS_FLOOR_RST
           && !o_default_mode))
      else $error("register reset did not restore defaults");
   kick_gap_a: assert property (o_watchdog_kick |=> (!o_watchdog_kick [*8]))
      else $error("watchdog kicks too close together");
   byte_len_a: assert property (
      ($rose(state == CCS_ST_MACK) && !$past(start_cond) && !$past(stop_cond))
      |-> ($past(bitcnt) == CCS_LAST_BIT))
      else $error("transmitted byte not eight bits");
   stretch_len_a: assert property ($rose(o_scl_oe) |-> (o_scl_oe [*2]) ##1 !o_scl_oe)
      else $error("clock stretch length wrong");
endmodule // ccs_config_slave
`default_nettype wire

// *** verif/ccs_host_model.sv ***
// bus master model for the serial configuration port
`timescale 1ns/1ns
`default_nettype none
module ccs_host_model (
   input  wire logic i_clk,
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_scl_low,
   output logic      o_sda_low
);
   initial {o_scl_low, o_sda_low} = 2'b00;
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // release clock, then wait (bounded) while the slave holds it low
   task automatic rise();
      o_scl_low <= 1'b0;
      for (int i = 0; i < 40 && i_scl !== 1'b1; i++) tick(1);
   endtask
   // eight clocks a bit when nothing stretches: 400 ns at the bench clock
   task automatic bit_io(input logic b, output logic r);
      tick(2);
      o_sda_low <= ~b;
      tick(2);
      rise();
      tick(2);
      r = i_sda;
      tick(1);
      o_scl_low <= 1'b1;
   endtask
   task automatic xfer(input logic [7:0] d, input logic a_in,
                       output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(a_in, r);
      ack = ~r;
   endtask
   // start: data falls with clock high; stop: data rises with clock high
   task automatic cond(input logic stop);
      tick(3);
      o_sda_low <= stop;
      tick(2);
      rise();
      tick(3);
      o_sda_low <= ~stop;
      tick(4);
      o_scl_low <= ~stop;
   endtask
endmodule // ccs_host_model
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the charger configuration slave
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import ccs_pkg::*;
   logic             i_clk, i_reset, psel, boost, wdx, scl_o, scl_oe, sda_o, sda_oe;
   logic             h_scl, h_sda, chg, kick, dflt;
   logic [6:0]       flt;
   logic [7:0]       sts;
   ccs_source_ctrl_t src;
   ccs_power_cfg_t   cfg;
   int               n_fail, compares, kicks;
   wire scl = !h_scl && !(scl_oe && !scl_o);
   wire sda = !h_sda && !(sda_oe && !sda_o);
   ccs_config_slave i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_scl(scl), .o_scl_o(scl_o),
      .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
      .i_source_select(psel), .i_boost_request(boost), .i_status(sts), .i_fault(flt),
      .i_watchdog_expired(wdx), .o_source_ctrl(src), .o_power_cfg(cfg),
      .o_charge_active(chg), .o_watchdog_kick(kick), .o_default_mode(dflt));
   ccs_host_model i_host (.i_clk(i_clk), .i_scl(scl), .i_sda(sda), .o_scl_low(h_scl),
      .o_sda_low(h_sda));
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   always @(posedge i_clk) if (kick === 1'b1) kicks++;
   task automatic chk(input logic [7:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // a host abandons the transfer with a stop at the first refusal
   task automatic wr(input logic [6:0] adr, input logic [7:0] r, d0, d1, input int n,
                     output logic [7:0] a);
      logic [7:0] q;
      a = {7'h00, n < 2};
      i_host.cond(1'b0);
      i_host.xfer({adr, 1'b0}, 1'b1, q, a[3]);
      if (a[3]) i_host.xfer(r, 1'b1, q, a[2]);
      if (a[2] && n > 0) i_host.xfer(d0, 1'b1, q, a[1]);
      if (a[1] && n > 1) i_host.xfer(d1, 1'b1, q, a[0]);
      // a read keeps the bus for its repeated start
      if (n > 0 || !a[2]) i_host.cond(1'b1);
   endtask
   task automatic rd(input logic [7:0] r, output logic [7:0] d0, d1);
      logic a;
      wr(CCS_SLAVE_ADDR, r, 8'h00, 8'h00, 0, d0);
      i_host.cond(1'b0);
      i_host.xfer({CCS_SLAVE_ADDR, 1'b1}, 1'b1, d0, a);
      i_host.xfer(8'hFF, 1'b0, d0, a);
      i_host.xfer(8'hFF, 1'b1, d1, a);
      i_host.cond(1'b1);
   endtask
   task automatic t_regs();
      logic [7:0] a, d0, d1;
      chk(src, 8'h37);
      chk({2'b00, cfg}, 8'h1B);
      wr(CCS_SLAVE_ADDR, 8'h01, 8'h10, 8'h00, 1, a);
      chk(a, 8'h0F);
      chk({6'h00, dflt, chg}, 8'h01);
      for (int c = 0; c < 8; c++) begin
         wr(CCS_SLAVE_ADDR, 8'h00, {5'h09, c[2:0]}, 8'h00, 1, a);
         chk(src, {5'h09, c[2:0]});
      end
      wr(CCS_SLAVE_ADDR, 8'h00, 8'h80, 8'h2A, 2, a);
      chk({src[7], chg, cfg}, 8'h AA);
      rd(8'h00, d0, d1);
      chk(d0, 8'h80);
      chk(d1, 8'h2A);
   endtask
   task automatic t_refuse();
      logic [7:0] a, d0, d1;
      wr(7'h6A, 8'h01, 8'h00, 8'h00, 1, a);
      chk(a, 8'h01);
      wr(CCS_SLAVE_ADDR, 8'h0B, 8'h00, 8'h00, 1, a);
      chk(a, 8'h09);
      wr(CCS_SLAVE_ADDR, 8'h08, 8'h00, 8'h00, 1, a);
      chk(a, 8'h0D);
      chk({2'b00, cfg}, 8'h2A);
      wr(CCS_SLAVE_ADDR, 8'h07, 8'h5A, 8'h00, 2, a);
      chk(a, 8'h0E);
      rd(8'h07, d0, d1);
      chk(d0, 8'h5A);
      chk(d1, 8'hC3);
      flt <= 7'h05;
      @(posedge i_clk);
      flt <= 7'h00;
      rd(8'h08, d0, d1);
      chk(d0, 8'hC3);
      chk(d1, 8'h00);
      rd(8'h09, d0, d1);
      chk(d0, 8'h05);
      rd(8'h09, d0, d1);
      chk(d0, 8'h00);
   endtask
   task automatic t_kick();
      logic [7:0] a;
      kicks = 0;
      wr(CCS_SLAVE_ADDR, 8'h01, 8'h5B, 8'h00, 1, a);
      wr(CCS_SLAVE_ADDR, 8'h01, 8'h5B, 8'h00, 1, a);
      psel <= 1'b1;
      boost <= 1'b1;
      repeat (400) @(posedge i_clk);
      wr(CCS_SLAVE_ADDR, 8'h01, 8'h80, 8'h00, 1, a);
      chk(src, 8'h32);
      chk({6'h00, cfg[0], dflt}, 8'h02);
      wr(CCS_SLAVE_ADDR, 8'h01, 8'h5B, 8'h00, 1, a);
      chk(kicks[7:0], 8'h02);
      wdx <= 1'b1;
      @(posedge i_clk);
      wdx <= 1'b0;
      @(posedge i_clk);
      chk({7'h00, dflt}, 8'h01);
   endtask
   task automatic tally_and_finish();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      {i_reset, psel, boost, wdx, flt} = 11'h400;
      sts = 8'hC3;
      repeat (3) @(posedge i_clk);
      i_reset <= 1'b0;
      repeat (6) @(posedge i_clk);
      t_regs();
      t_refuse();
      t_kick();
      tally_and_finish();
   end
   initial begin
      #2000000;
      n_fail++;
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
